// ==== uems_regs.sv ====
// Purpose: uncorrectable error mask and severity bank with apb slave and interrupt
// Assumes: errEvent pulses come from ref_clk logic; portDownStrap is a pin
// Notes:   mask/severity survive hotReset, only reset_n clears them
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module uems_regs
  import uems_pkg::*;
(
  // clock and power-on reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // non-power-on reset, one cycle, ref_clk domain
  input  wire logic                  hotReset,
  // port role strap pin
  input  wire logic                  portDownStrap,
  // apb slave
  input  wire uems_apb_req_t         apbReq,
  output uems_apb_rsp_t              apbRsp,
  // detected errors
  input  wire logic [UEMS_ERR_W-1:0] errEvent,
  // toward header log and message builder
  output uems_report_t               report,
  // interrupt
  output logic                       irq
);

  logic                  strapMeta;
  logic                  strapSync;
  logic                  isDown;
  logic [UEMS_ERR_W-1:0] mask;
  logic [UEMS_ERR_W-1:0] sev;
  logic [UEMS_ERR_W-1:0] intStat;
  logic [UEMS_ERR_W-1:0] intEn;
  logic                  setupPhase;
  logic                  wrDone;
  logic [UEMS_DATA_W-1:0] wrMaskBits;
  logic [UEMS_DATA_W-1:0] next_rdata;
  logic                  next_err;
  logic [UEMS_ERR_W-1:0] next_intStat;

  // strap is a pin: two flops before use
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      strapMeta <= 1'b0;
      strapSync <= 1'b0;
    end else begin
      strapMeta <= portDownStrap;
      strapSync <= strapMeta;
    end
  end

  // port role follows the synchronised strap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      isDown <= 1'b0;
    end else begin
      isDown <= strapSync;
    end
  end

  // apb phases: answer is prepared in setup, so access never waits
  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign wrDone = apbReq.psel & apbReq.penable & apbRsp.pready
                  & apbReq.pwrite & ~apbRsp.pslverr;

  // byte strobes widened to a bit mask
  for (genvar bi = 0; bi < 4; bi++) begin : g_strb
    assign wrMaskBits[bi*8 +: 8] = {8{apbReq.pstrb[bi]}};
  end

  // read mux and decode, reserved bits read as zero
  always_comb begin
    next_rdata = UEMS_RD_NONE;
    next_err   = 1'b0;
    if (apbReq.paddr == UEMS_OFF_MASK) begin
      next_rdata[UEMS_ERR_W-1:0] = mask;
    end else if (apbReq.paddr == UEMS_OFF_SEV) begin
      next_rdata[UEMS_ERR_W-1:0] = sev;
    end else if (apbReq.paddr == UEMS_OFF_IST) begin
      next_rdata[UEMS_ERR_W-1:0] = intStat;
    end else if (apbReq.paddr == UEMS_OFF_IEN) begin
      next_rdata[UEMS_ERR_W-1:0] = intEn;
    end else begin
      next_err = 1'b1; // unmapped offset
    end
  end

  // apb answer flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      apbRsp <= '0;
    end else if (setupPhase) begin
      apbRsp.pready  <= 1'b1;
      apbRsp.pslverr <= next_err;
      apbRsp.prdata  <= apbReq.pwrite ? UEMS_RD_NONE : next_rdata;
    end else begin
      apbRsp <= '0;
    end
  end

  // mask: sticky, only power-on reset clears it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mask <= UEMS_MASK_RST;
    end else if (wrDone && apbReq.paddr == UEMS_OFF_MASK) begin
      // reserved bits ignore writes
      mask <= ((mask & ~wrMaskBits[UEMS_ERR_W-1:0])
              | (apbReq.pwdata[UEMS_ERR_W-1:0] & wrMaskBits[UEMS_ERR_W-1:0]))
              & UEMS_IMPL;
    end
  end

  // severity: sticky, listed kinds come up fatal
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sev <= UEMS_SEV_RST;
    end else if (wrDone && apbReq.paddr == UEMS_OFF_SEV) begin
      sev <= ((sev & ~wrMaskBits[UEMS_ERR_W-1:0])
             | (apbReq.pwdata[UEMS_ERR_W-1:0] & wrMaskBits[UEMS_ERR_W-1:0]))
             & UEMS_IMPL;
    end
  end

  // interrupt status: write one clears, a new event beats the clear
  always_comb begin
    next_intStat = intStat;
    if (hotReset) begin
      next_intStat = UEMS_IST_RST;
    end else if (wrDone && apbReq.paddr == UEMS_OFF_IST) begin
      next_intStat = intStat
                     & ~(apbReq.pwdata[UEMS_ERR_W-1:0] & wrMaskBits[UEMS_ERR_W-1:0]);
    end
    next_intStat = next_intStat | (errEvent & UEMS_IMPL);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intStat <= UEMS_IST_RST;
    end else begin
      intStat <= next_intStat;
    end
  end

  // interrupt enable is not sticky, a hot reset clears it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intEn <= UEMS_IEN_RST;
    end else if (hotReset) begin
      intEn <= UEMS_IEN_RST;
    end else if (wrDone && apbReq.paddr == UEMS_OFF_IEN) begin
      intEn <= ((intEn & ~wrMaskBits[UEMS_ERR_W-1:0])
               | (apbReq.pwdata[UEMS_ERR_W-1:0] & wrMaskBits[UEMS_ERR_W-1:0]))
               & UEMS_IMPL;
    end
  end

  // level interrupt, registered so it comes straight from a flop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_intStat & intEn);
    end
  end

  // gating of events toward log and messages
  uems_gate u_gate (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .errEvent (errEvent),
    .mask     (mask),
    .sev      (sev),
    .isDown   (isDown),
    .report   (report)
  );

  // checks on the bank
  a_mask_train: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_TRAIN] && mask[UEMS_B_TRAIN] |=> !report.reported[UEMS_B_TRAIN])
    else $error("masked training error reported");

  a_mask_dlp: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_DLP] && mask[UEMS_B_DLP] && errEvent == (22'h1 << UEMS_B_DLP)
    |=> !report.logCapture && !report.fatalMsg && !report.nonFatalMsg)
    else $error("masked link protocol error logged");

  a_mask_sdown: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_SDOWN] && isDown |=> report.reported[UEMS_B_SDOWN] == !$past(mask[5]))
    else $error("surprise down mask wrong on downstream port");

  a_mask_poison: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_POISON] |=>
      report.reported[UEMS_B_POISON] == !$past(mask[UEMS_B_POISON]))
    else $error("poisoned packet masking wrong");

  a_mask_fcp: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_FCP] && mask[UEMS_B_FCP] |=> !report.reported[UEMS_B_FCP])
    else $error("masked flow control error reported");

  a_mask_cto_ca: assert property (@(posedge ref_clk) disable iff (!reset_n)
    report.reported[15:14] == ($past(errEvent[15:14]) & ~$past(mask[15:14])))
    else $error("timeout or abort masking wrong");

  a_mask_uc_ro: assert property (@(posedge ref_clk) disable iff (!reset_n)
    report.reported[17:16] == ($past(errEvent[17:16]) & ~$past(mask[17:16])))
    else $error("completion or overflow masking wrong");

  a_mask_mal_crc: assert property (@(posedge ref_clk) disable iff (!reset_n)
    report.reported[19:18] == ($past(errEvent[19:18]) & ~$past(mask[19:18])))
    else $error("malformed or crc masking wrong");

  a_mask_ureq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_UREQ] && !mask[UEMS_B_UREQ] |=> report.reported[UEMS_B_UREQ]
      && report.logCapture)
    else $error("unmasked unsupported request not reported");

  a_sev_fatal: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_MALF] && !mask[UEMS_B_MALF] |=>
      ($past(sev[UEMS_B_MALF]) ? report.fatalMsg
                                : report.nonFatalMsg))
    else $error("malformed severity class wrong");

  a_sev_upstream: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent == (22'h1 << UEMS_B_SDOWN) && !isDown
    |=> report.reported[UEMS_B_SDOWN] && report.fatalMsg && !report.nonFatalMsg)
    else $error("upstream surprise down not fatal");

  a_sticky_hot: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hotReset && !wrDone |=> $stable(mask) && $stable(sev))
    else $error("hot reset disturbed sticky bits");

  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ((mask | sev | intStat | intEn) & ~UEMS_IMPL) == '0)
    else $error("reserved bit set");

  a_apb_ready: assert property (@(posedge ref_clk) disable iff (!reset_n)
    setupPhase |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("apb answer timing wrong");

  // surprise down on an upstream port slips past its mask
  a_sdown_up: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_SDOWN] && !isDown |=> report.reported[UEMS_B_SDOWN])
    else $error("upstream surprise down was masked");

  // downstream surprise down follows its own severity bit
  a_sev_down: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent == (22'h1 << UEMS_B_SDOWN) && isDown && !mask[UEMS_B_SDOWN] |=>
      report.fatalMsg == $past(sev[UEMS_B_SDOWN])
      && report.nonFatalMsg == !$past(sev[UEMS_B_SDOWN]))
    else $error("downstream surprise down severity wrong");

  // poisoned packets come up non-fatal and obey a rewrite
  a_sev_poison: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent == (22'h1 << UEMS_B_POISON) && !mask[UEMS_B_POISON] |=>
      report.fatalMsg == $past(sev[UEMS_B_POISON])
      && report.nonFatalMsg == !$past(sev[UEMS_B_POISON]))
    else $error("poisoned packet severity wrong");

  // access violations gate like the rest
  a_mask_acs: assert property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_ACS] && mask[UEMS_B_ACS] |=> !report.reported[UEMS_B_ACS])
    else $error("masked access violation reported");

  // unimplemented kinds never leave the bank
  a_rsvd_report: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (report.reported & ~UEMS_IMPL) == '0)
    else $error("reserved error kind reported");

  // the header log strobe goes with every reported kind and only then
  a_log_any: assert property (@(posedge ref_clk) disable iff (!reset_n)
    report.logCapture == (|report.reported))
    else $error("log capture strobe out of step");

  // a full-word write lands exactly, reserved bits dropped
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrDone && apbReq.paddr == UEMS_OFF_MASK && apbReq.pstrb == 4'hf
    |=> mask == (UEMS_IMPL & $past(apbReq.pwdata[UEMS_ERR_W-1:0])))
    else $error("mask write did not land");

  // only a bus write moves the sticky registers
  a_mask_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(wrDone && apbReq.paddr == UEMS_OFF_MASK) |=> $stable(mask))
    else $error("mask moved without a write");

  a_sev_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(wrDone && apbReq.paddr == UEMS_OFF_SEV) |=> $stable(sev))
    else $error("severity moved without a write");

  // refused offsets answer with an error and no data
  a_apb_slverr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    setupPhase && apbReq.paddr != UEMS_OFF_MASK && apbReq.paddr != UEMS_OFF_SEV
    && apbReq.paddr != UEMS_OFF_IST && apbReq.paddr != UEMS_OFF_IEN
    |=> apbRsp.pslverr && apbRsp.prdata == '0)
    else $error("unmapped offset not refused");

  a_apb_wrdata: assert property (@(posedge ref_clk) disable iff (!reset_n)
    setupPhase && apbReq.pwrite |=> apbRsp.prdata == '0)
    else $error("read data driven during a write");

  // status keeps every event it saw, even against a clear or hot reset
  a_ist_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (intStat & $past(errEvent) & UEMS_IMPL) == ($past(errEvent) & UEMS_IMPL))
    else $error("event lost from interrupt status");

  a_ist_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wrDone && apbReq.paddr == UEMS_OFF_IST && apbReq.pstrb == 4'hf && errEvent == '0
    |=> (intStat & $past(apbReq.pwdata[UEMS_ERR_W-1:0])) == '0)
    else $error("status bit survived its clear");

  // line follows status and the enable that stood when status was formed
  a_irq_source: assert property (@(posedge ref_clk) disable iff (!reset_n)
    irq == (|(intStat & $past(intEn))))
    else $error("interrupt line does not match status");

  a_hot_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hotReset |=> intEn == '0)
    else $error("hot reset left interrupt enables");

  c_masked_event: cover property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_ACS] && mask[UEMS_B_ACS]);
  c_fatal_msg: cover property (@(posedge ref_clk) disable iff (!reset_n)
    report.fatalMsg);
  c_irq_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
    irq ##[1:20] !irq);
  // upstream role and the set-against-clear race are the rarer paths
  c_upstream_sdown: cover property (@(posedge ref_clk) disable iff (!reset_n)
    errEvent[UEMS_B_SDOWN] && mask[UEMS_B_SDOWN] && !isDown);
  c_set_beats_clr: cover property (@(posedge ref_clk) disable iff (!reset_n)
    wrDone && apbReq.paddr == UEMS_OFF_IST && (|errEvent));

endmodule : uems_regs
`default_nettype wire

// ==== uems_pkg.sv ====
// Purpose: shared constants and carriers for the uncorrectable error mask/severity bank
// Assumes: 32-bit APB data, 12-bit configuration offsets
// Notes:   one bit per uncorrectable error kind, 22 bits, 13 kinds implemented
package uems_pkg;

  // widths
  localparam int UEMS_ERR_W  = 22;
  localparam int UEMS_ADDR_W = 12;
  localparam int UEMS_DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [UEMS_ADDR_W-1:0] UEMS_OFF_MASK = 12'h108;
  localparam logic [UEMS_ADDR_W-1:0] UEMS_OFF_SEV  = 12'h10c;
  localparam logic [UEMS_ADDR_W-1:0] UEMS_OFF_IST  = 12'h200;
  localparam logic [UEMS_ADDR_W-1:0] UEMS_OFF_IEN  = 12'h204;

  // error bit positions
  localparam int UEMS_B_TRAIN  = 0;
  localparam int UEMS_B_DLP    = 4;
  localparam int UEMS_B_SDOWN  = 5;
  localparam int UEMS_B_POISON = 12;
  localparam int UEMS_B_FCP    = 13;
  localparam int UEMS_B_CTO    = 14;
  localparam int UEMS_B_CABORT = 15;
  localparam int UEMS_B_UCPL   = 16;
  localparam int UEMS_B_ROVF   = 17;
  localparam int UEMS_B_MALF   = 18;
  localparam int UEMS_B_ECRC   = 19;
  localparam int UEMS_B_UREQ   = 20;
  localparam int UEMS_B_ACS    = 21;

  // implemented bits and reset values
  localparam logic [UEMS_ERR_W-1:0] UEMS_IMPL     = 22'h3ff031;
  localparam logic [UEMS_ERR_W-1:0] UEMS_MASK_RST = 22'h000000;
  localparam logic [UEMS_ERR_W-1:0] UEMS_SEV_RST  = 22'h062031;
  localparam logic [UEMS_ERR_W-1:0] UEMS_IST_RST  = 22'h000000;
  localparam logic [UEMS_ERR_W-1:0] UEMS_IEN_RST  = 22'h000000;
  localparam logic [UEMS_DATA_W-1:0] UEMS_RD_NONE = 32'h00000000;

  // apb request from the master
  typedef struct packed {
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [UEMS_ADDR_W-1:0] paddr;
    logic [UEMS_DATA_W-1:0] pwdata;
    logic [3:0]             pstrb;
  } uems_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic                   pready;
    logic                   pslverr;
    logic [UEMS_DATA_W-1:0] prdata;
  } uems_apb_rsp_t;

  // what leaves toward header log and message builder
  typedef struct packed {
    logic                  logCapture;
    logic                  fatalMsg;
    logic                  nonFatalMsg;
    logic [UEMS_ERR_W-1:0] reported;
  } uems_report_t;

endpackage : uems_pkg

// ==== uems_gate.sv ====
// Purpose: per-error gating of detected events by mask and severity
// Assumes: events are one-cycle pulses on ref_clk
// Notes:   outputs are registered, one cycle after the event
`timescale 1ns/100ps
`default_nettype none
module uems_gate
  import uems_pkg::*;
(
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // controls
  input  wire logic [UEMS_ERR_W-1:0] errEvent,
  input  wire logic [UEMS_ERR_W-1:0] mask,
  input  wire logic [UEMS_ERR_W-1:0] sev,
  input  wire logic                  isDown,
  // result
  output uems_report_t               report
);

  logic [UEMS_ERR_W-1:0] effMask;
  logic [UEMS_ERR_W-1:0] effSev;
  logic [UEMS_ERR_W-1:0] next_rep;

  // surprise down controls only count on a downstream port
  for (genvar gi = 0; gi < UEMS_ERR_W; gi++) begin : g_bit
    if (gi == UEMS_B_SDOWN) begin : g_sd
      assign effMask[gi] = mask[gi] & isDown;
      assign effSev[gi]  = isDown ? sev[gi] : UEMS_SEV_RST[gi];
    end else begin : g_pl
      assign effMask[gi] = mask[gi];
      assign effSev[gi]  = sev[gi];
    end
    // masked events neither log nor message
    assign next_rep[gi] = errEvent[gi] & ~effMask[gi] & UEMS_IMPL[gi];
  end

  // one registered pulse per reporting class
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      report <= '0;
    end else begin
      report.reported    <= next_rep;
      report.logCapture  <= |next_rep;
      report.fatalMsg    <= |(next_rep & effSev);
      report.nonFatalMsg <= |(next_rep & ~effSev);
    end
  end

endmodule : uems_gate
`default_nettype wire

// ==== uems_regs_tb.sv ====
// Purpose: self-checking bench for the uncorrectable error mask/severity bank
// Assumes: apb slave answers within a few cycles, report one cycle after an event
// Notes:   expectations come from the package layout and reset constants
`timescale 1ns/100ps
`default_nettype none
module uems_regs_tb
  import uems_pkg::*;
;
  logic                  ref_clk;
  logic                  reset_n;
  logic                  hotReset;
  logic                  portDownStrap;
  uems_apb_req_t         apbReq;
  uems_apb_rsp_t         apbRsp;
  logic [UEMS_ERR_W-1:0] errEvent;
  uems_report_t          report;
  logic                  irq;
  int                    nErrors;
  int                    samplesChecked;
  logic [31:0]           rd;
  logic                  err;

  uems_regs uut (
    .ref_clk       (ref_clk),
    .reset_n       (reset_n),
    .hotReset      (hotReset),
    .portDownStrap (portDownStrap),
    .apbReq        (apbReq),
    .apbRsp        (apbRsp),
    .errEvent      (errEvent),
    .report        (report),
    .irq           (irq)
  );

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  task automatic testDone();
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : testDone

  task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : checkWord

  task automatic checkBit(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : checkBit

  // one apb transfer, entered just after a rising edge; an idle cycle follows
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                     input logic [3:0] strb, output logic [31:0] rdata, output logic slverr);
    int n;
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= addr;
    apbReq.pwdata  <= wdata;
    apbReq.pstrb   <= strb;
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (apbRsp.pready !== 1'b1) begin
      nErrors++;
      testDone();
    end
    rdata = apbRsp.prdata;
    slverr = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, data, strb, d, e);
    checkBit("write pslverr", 1'b0, e);
  endtask : wr

  task automatic rdChk(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h00000000, 4'hf, d, e);
    checkWord(what, exp, d);
    checkBit("read pslverr", 1'b0, e);
  endtask : rdChk

  // pulse events for one cycle and look at the registered report after it
  task automatic fire(input logic [21:0] ev, input logic [21:0] expRep, input logic expFat,
                      input logic expNf, input logic expIrq);
    errEvent <= ev;
    @(posedge ref_clk);
    errEvent <= '0;
    @(posedge ref_clk);
    checkWord("reported", {10'h000, expRep}, {10'h000, report.reported});
    checkBit("logCapture", |expRep, report.logCapture);
    checkBit("fatalMsg", expFat, report.fatalMsg);
    checkBit("nonFatalMsg", expNf, report.nonFatalMsg);
    checkBit("irq", expIrq, irq);
  endtask : fire

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    hotReset = 1'b0;
    portDownStrap = 1'b1;
    apbReq = '0;
    errEvent = '0;
    nErrors = 0;
    samplesChecked = 0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // strap needs three edges to reach the port role flop
    repeat (5) @(posedge ref_clk);
    rdChk("mask reset", UEMS_OFF_MASK, 32'h00000000);
    rdChk("sev reset", UEMS_OFF_SEV, {10'h000, UEMS_SEV_RST});
    wr(UEMS_OFF_MASK, 32'hffffffff, 4'hf);
    rdChk("mask all", UEMS_OFF_MASK, {10'h000, UEMS_IMPL});
    fire(22'h3fffff, 22'h000000, 1'b0, 1'b0, 1'b0);
    // only byte lane 0 is cleared
    wr(UEMS_OFF_MASK, 32'h00000000, 4'h1);
    rdChk("mask lane", UEMS_OFF_MASK, {10'h000, UEMS_IMPL & 22'h3fff00});
    wr(UEMS_OFF_MASK, 32'h00000000, 4'hf);
    fire(~UEMS_IMPL, 22'h000000, 1'b0, 1'b0, 1'b0);
    fire(22'h3fffff, UEMS_IMPL, 1'b1, 1'b1, 1'b0);
    // each kind alone, first open then masked
    for (int i = 0; i < UEMS_ERR_W; i++) begin
      if (UEMS_IMPL[i]) begin
        wr(UEMS_OFF_MASK, 32'h00000000, 4'hf);
        fire(22'h1 << i, 22'h1 << i, UEMS_SEV_RST[i], !UEMS_SEV_RST[i], 1'b0);
        wr(UEMS_OFF_MASK, 32'h1 << i, 4'hf);
        fire(22'h1 << i, 22'h000000, 1'b0, 1'b0, 1'b0);
      end
    end
    // inverted severity
    wr(UEMS_OFF_MASK, 32'h00000000, 4'hf);
    wr(UEMS_OFF_SEV, ~{10'h000, UEMS_SEV_RST}, 4'hf);
    rdChk("sev inv", UEMS_OFF_SEV, {10'h000, UEMS_IMPL & ~UEMS_SEV_RST});
    fire(22'h1 << UEMS_B_MALF, 22'h1 << UEMS_B_MALF, 1'b0, 1'b1, 1'b0);
    fire(22'h1 << UEMS_B_CTO, 22'h1 << UEMS_B_CTO, 1'b1, 1'b0, 1'b0);
    fire(22'h1 << UEMS_B_SDOWN, 22'h1 << UEMS_B_SDOWN, 1'b0, 1'b1, 1'b0);
    // upstream port ignores mask and severity of surprise down
    portDownStrap <= 1'b0;
    repeat (5) @(posedge ref_clk);
    wr(UEMS_OFF_MASK, 32'h1 << UEMS_B_SDOWN, 4'hf);
    fire(22'h1 << UEMS_B_SDOWN, 22'h1 << UEMS_B_SDOWN, 1'b1, 1'b0, 1'b0);
    portDownStrap <= 1'b1;
    repeat (5) @(posedge ref_clk);
    fire(22'h1 << UEMS_B_SDOWN, 22'h000000, 1'b0, 1'b0, 1'b0);
    // interrupt: status is sticky, enable gates the line, writing one clears
    wr(UEMS_OFF_IST, 32'hffffffff, 4'hf);
    rdChk("intStat clr", UEMS_OFF_IST, 32'h00000000);
    wr(UEMS_OFF_IEN, 32'h1 << UEMS_B_MALF, 4'hf);
    rdChk("intEn", UEMS_OFF_IEN, 32'h1 << UEMS_B_MALF);
    fire(22'h1 << UEMS_B_SDOWN, 22'h000000, 1'b0, 1'b0, 1'b0);
    fire(22'h1 << UEMS_B_MALF, 22'h1 << UEMS_B_MALF, 1'b0, 1'b1, 1'b1);
    rdChk("intStat set", UEMS_OFF_IST, 32'h00040020);
    wr(UEMS_OFF_IST, 32'h1 << UEMS_B_MALF, 4'hf);
    @(posedge ref_clk);
    checkBit("irq cleared", 1'b0, irq);
    rdChk("intStat left", UEMS_OFF_IST, 32'h1 << UEMS_B_SDOWN);
    // unmapped address is refused
    apb(1'b0, 12'h0f0, 32'h00000000, 4'hf, rd, err);
    checkBit("unmapped pslverr", 1'b1, err);
    checkWord("unmapped prdata", 32'h00000000, rd);
    // hot reset keeps the sticky bank
    hotReset <= 1'b1;
    @(posedge ref_clk);
    hotReset <= 1'b0;
    @(posedge ref_clk);
    rdChk("mask hot", UEMS_OFF_MASK, 32'h1 << UEMS_B_SDOWN);
    rdChk("sev hot", UEMS_OFF_SEV, {10'h000, UEMS_IMPL & ~UEMS_SEV_RST});
    rdChk("intEn hot", UEMS_OFF_IEN, 32'h00000000);
    rdChk("intStat hot", UEMS_OFF_IST, 32'h00000000);
    // power-on reset clears it
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    rdChk("mask por", UEMS_OFF_MASK, 32'h00000000);
    rdChk("sev por", UEMS_OFF_SEV, {10'h000, UEMS_SEV_RST});
    testDone();
  end
endmodule : uems_regs_tb
`default_nettype wire
